// ===== logic/rxi_pkg.sv
// Constants shared by the reset and external interrupt front end
package rxi_pkg;
  localparam int unsigned RXI_CLK_PERIOD_NS = 10;
  localparam int unsigned RXI_WD_PULSE_CYCLES = 8;
  localparam logic [3:0] RXI_WD_PULSE_LAST = 4'(RXI_WD_PULSE_CYCLES - 1);
  localparam logic [15:0] RXI_RESET_VECTOR = 16'h0000;
  localparam logic RXI_POL_FALLING = 1'b0;
  localparam logic RXI_POL_RISING = 1'b1;
  localparam logic [1:0] RXI_SYNC_RESET = 2'h3;

  typedef enum logic [1:0] {
    RXI_ST_RUN = 2'b00,
    RXI_ST_HALT = 2'b01,
    RXI_ST_WDPULSE = 2'b10
  } rxi_state_t;
endpackage : rxi_pkg

// ===== logic/rxi_edge_det.sv
// Synchroniser and edge detector for one external interrupt pin
`timescale 1ns/1ps
module rxi_edge_det
  import rxi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  input wire logic rise_sel,
  input wire logic enable,
  output logic req
);
  typedef struct packed {
    logic [2:0] fill;
    logic [1:0] sync;
    logic prev;
    logic req;
  } rxi_ed_t;

  rxi_ed_t st_ff;
  rxi_ed_t nxt_st_ff;

  always_comb begin
    nxt_st_ff = st_ff;
    // Idle level of the pin is unknown, so no edge counts until both samples come from it
    nxt_st_ff.fill = {st_ff.fill[1:0], 1'b1};
    nxt_st_ff.sync = {st_ff.sync[0], pin_in};
    nxt_st_ff.prev = st_ff.sync[1];
    // One request per qualified edge; new level is held, so the sample pair sees it once
    if (rise_sel == RXI_POL_RISING) begin
      nxt_st_ff.req = enable && st_ff.fill[2] && st_ff.sync[1] && !st_ff.prev;
    end else begin
      nxt_st_ff.req = enable && st_ff.fill[2] && !st_ff.sync[1] && st_ff.prev;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{fill: 3'h0, sync: RXI_SYNC_RESET, prev: 1'b1, req: 1'b0};
    end else begin
      st_ff <= nxt_st_ff;
    end
  end

  assign req = st_ff.req;
endmodule : rxi_edge_det

// ===== logic/rxi_reset_irq.sv
// Reset pin control and external interrupt front end
// ==========================================================
`timescale 1ns/1ps
module rxi_reset_irq
  import rxi_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic system_reset_pin_in,
  output logic system_reset_pin_out,
  output logic system_reset_pin_oe,
  input wire logic wd_overflow,
  output logic core_halt,
  output logic pc_force_zero,
  output logic [15:0] fetch_addr,
  output logic fetch_start,
  input wire logic global_irq_mask,
  input wire logic nmi_b_pin,
  output logic nmi_req,
  input wire logic user_irq_one_pin_in,
  output logic user_irq_one_pin_out,
  output logic user_irq_one_pin_oe,
  input wire logic irq_one_rise_sel,
  input wire logic irq_one_gpio_mode,
  input wire logic port_a_bit2_io_dir,
  input wire logic port_a_bit2_io_out,
  output logic port_a_bit2_io_in,
  output logic user_irq_one_req,
  input wire logic user_irq_two_pin,
  input wire logic irq_two_rise_sel,
  output logic user_irq_two_req,
  output logic conv_start_req,
  output logic user_irq_req_masked
);
  // ==========================================================
  // State
  typedef struct packed {
    rxi_state_t state;
    logic [3:0] cnt;
    logic [1:0] rst_sync;
    logic [1:0] nmi_sync;
    logic nmi_prev;
    logic nmi_fell;
    logic nmi_req;
    logic fetch_start;
    logic [1:0] io_sync;
    logic io_in;
    logic irq1;
    logic irq2;
  } rxi_top_t;

  rxi_top_t st_ff;
  rxi_top_t nxt_st_ff;
  logic irq1_raw;
  logic irq2_raw;

  rxi_edge_det u_irq1 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(user_irq_one_pin_in),
    .rise_sel(irq_one_rise_sel),
    .enable(!irq_one_gpio_mode),
    .req(irq1_raw)
  );

  // Second input has no I/O mode, so its detection is always on
  rxi_edge_det u_irq2 (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(user_irq_two_pin),
    .rise_sel(irq_two_rise_sel),
    .enable(1'b1),
    .req(irq2_raw)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st_ff = st_ff;
    // Reset pin is trusted only after two flops; the board may pull it at any time
    nxt_st_ff.rst_sync = {st_ff.rst_sync[0], system_reset_pin_in};
    nxt_st_ff.nmi_sync = {st_ff.nmi_sync[0], nmi_b_pin};
    nxt_st_ff.nmi_prev = st_ff.nmi_sync[1];
    nxt_st_ff.io_sync = {st_ff.io_sync[0], user_irq_one_pin_in};
    nxt_st_ff.io_in = st_ff.io_sync[1];
    nxt_st_ff.fetch_start = 1'b0;
    nxt_st_ff.irq1 = irq1_raw;
    nxt_st_ff.irq2 = irq2_raw;
    // Falling edge arms, next low sample confirms; mask is never consulted
    nxt_st_ff.nmi_fell = st_ff.nmi_prev && !st_ff.nmi_sync[1];
    nxt_st_ff.nmi_req = st_ff.nmi_fell && !st_ff.nmi_sync[1];
    unique case (st_ff.state)
      RXI_ST_RUN: begin
        if (wd_overflow) begin
          nxt_st_ff.state = RXI_ST_WDPULSE;
          nxt_st_ff.cnt = 4'h0;
        end else if (!st_ff.rst_sync[1]) begin
          nxt_st_ff.state = RXI_ST_HALT;
        end
      end
      RXI_ST_WDPULSE: begin
        nxt_st_ff.cnt = st_ff.cnt + 4'h1;
        if (st_ff.cnt == RXI_WD_PULSE_LAST) begin
          nxt_st_ff.state = RXI_ST_HALT;
        end
      end
      RXI_ST_HALT: begin
        // Pin still seen low from our own pulse for two sync stages; waits it out
        if (st_ff.rst_sync[1]) begin
          nxt_st_ff.state = RXI_ST_RUN;
          nxt_st_ff.fetch_start = 1'b1;
        end
      end
      default: nxt_st_ff.state = RXI_ST_HALT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{state: RXI_ST_HALT, cnt: 4'h0, rst_sync: 2'h0, nmi_sync: RXI_SYNC_RESET,
                 nmi_prev: 1'b1, nmi_fell: 1'b0, nmi_req: 1'b0, fetch_start: 1'b0,
                 io_sync: 2'h0, io_in: 1'b0, irq1: 1'b0, irq2: 1'b0};
    end else begin
      st_ff <= nxt_st_ff;
    end
  end

  // ==========================================================
  // Outputs
  // Pin is only ever pulled low; the board pull-up supplies the high level
  assign system_reset_pin_out = 1'b0;
  assign system_reset_pin_oe = (st_ff.state == RXI_ST_WDPULSE);
  assign core_halt = (st_ff.state != RXI_ST_RUN);
  assign pc_force_zero = core_halt;
  assign fetch_addr = RXI_RESET_VECTOR;
  assign fetch_start = st_ff.fetch_start;
  assign nmi_req = st_ff.nmi_req;
  assign user_irq_one_pin_out = port_a_bit2_io_out;
  assign user_irq_one_pin_oe = irq_one_gpio_mode && port_a_bit2_io_dir;
  assign port_a_bit2_io_in = st_ff.io_in;
  assign user_irq_one_req = st_ff.irq1;
  assign user_irq_two_req = st_ff.irq2;
  assign conv_start_req = st_ff.irq2;
  assign user_irq_req_masked = (st_ff.irq1 || st_ff.irq2) && !global_irq_mask;

  // ==========================================================
  // Checks
  // Delays below count two sync flops, the edge register and the request register
  a_wd_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(system_reset_pin_oe) |-> system_reset_pin_oe [*8] ##1 !system_reset_pin_oe)
    else $error("reset pulse not eight cycles");
  a_wd_starts: assert property (@(posedge core_clk) disable iff (!rst_b)
    (wd_overflow && st_ff.state == RXI_ST_RUN) |=> system_reset_pin_oe && core_halt)
    else $error("watchdog did not drive reset");
  a_halt_on_rst: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!st_ff.rst_sync[1] && !wd_overflow) |=> core_halt && pc_force_zero)
    else $error("core not halted in reset");
  a_fetch_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(core_halt) |-> fetch_start && fetch_addr == 16'h0000)
    else $error("restart not at zero");
  a_nmi_unmasked: assert property (@(posedge core_clk) disable iff (!rst_b)
    (st_ff.nmi_prev && !st_ff.nmi_sync[1]) ##1 !st_ff.nmi_sync[1] |=> nmi_req)
    else $error("nmi missed");
  a_nmi_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
    nmi_req |-> !$past(nmi_b_pin, 3) && !$past(nmi_b_pin, 4) && $past(nmi_b_pin, 5))
    else $error("nmi without low level");
  a_irq1_once: assert property (@(posedge core_clk) disable iff (!rst_b)
    user_irq_one_req |=> !user_irq_one_req)
    else $error("double irq1 request");
  a_irq1_gpio: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_one_gpio_mode [*2] |=> !user_irq_one_req)
    else $error("irq1 fired in io mode");
  a_irq2_start: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_start_req |-> user_irq_two_req && ($past(irq_two_rise_sel, 2) ?
      ($past(user_irq_two_pin, 4) && !$past(user_irq_two_pin, 5)) :
      (!$past(user_irq_two_pin, 4) && $past(user_irq_two_pin, 5))))
    else $error("converter start without selected edge");
  a_irq1_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
    user_irq_one_req |-> ($past(irq_one_rise_sel, 2) ?
      ($past(user_irq_one_pin_in, 4) && !$past(user_irq_one_pin_in, 5)) :
      (!$past(user_irq_one_pin_in, 4) && $past(user_irq_one_pin_in, 5))))
    else $error("irq1 without selected edge");
  a_fetch_once: assert property (@(posedge core_clk) disable iff (!rst_b)
    fetch_start |=> !fetch_start)
    else $error("restart pulse too long");
  a_halt_exit: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(core_halt) |-> $past(st_ff.rst_sync[1]))
    else $error("core left halt with reset pin low");
  a_run_no_halt: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!core_halt && st_ff.rst_sync[1] && !wd_overflow) |=> !core_halt)
    else $error("core halted without cause");
  a_wd_end: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(system_reset_pin_oe) |-> core_halt)
    else $error("core ran at end of reset pulse");
  a_nmi_once: assert property (@(posedge core_clk) disable iff (!rst_b)
    nmi_req |=> !nmi_req)
    else $error("double nmi request");
  a_irq2_once: assert property (@(posedge core_clk) disable iff (!rst_b)
    user_irq_two_req |=> !user_irq_two_req)
    else $error("double irq2 request");
  // Input path is three registers deep; skipped while the history still reaches reset
  a_io_in: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(rst_b, 3) |-> port_a_bit2_io_in == $past(user_irq_one_pin_in, 3))
    else $error("io input level wrong");
  c_wd_reset: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(system_reset_pin_oe));
  c_nmi: cover property (@(posedge core_clk) disable iff (!rst_b) nmi_req);
  c_irq1: cover property (@(posedge core_clk) disable iff (!rst_b) user_irq_one_req);
  c_irq2: cover property (@(posedge core_clk) disable iff (!rst_b) user_irq_two_req);
  c_restart: cover property (@(posedge core_clk) disable iff (!rst_b) fetch_start);
endmodule : rxi_reset_irq

// ===== sim/rxi_board.sv
// Board-side model driving the reset, nmi and user interrupt pins
`timescale 1ns/1ps
module rxi_board (
  input wire logic core_clk,
  input wire logic rst_oe,
  output logic rst_lvl,
  output logic nmi_b,
  output logic irq1,
  output logic irq2
);
  logic rst_drv;
  // Open-drain reset line with pull-up: low if either side pulls
  assign rst_lvl = !(rst_drv | rst_oe);
  initial begin
    rst_drv = 1'b0;
    nmi_b = 1'b1;
    irq1 = 1'b0;
    irq2 = 1'b0;
  end
  task hold_rst(input int n);
    @(posedge core_clk) #1 rst_drv = 1'b1;
    repeat (n) @(posedge core_clk);
    #1 rst_drv = 1'b0;
  endtask : hold_rst
  task nmi_pulse();
    @(posedge core_clk) #1 nmi_b = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 nmi_b = 1'b1;
  endtask : nmi_pulse
  task set_irq(input logic one, input logic v);
    @(posedge core_clk) #1 if (one) irq1 = v; else irq2 = v;
    repeat (3) @(posedge core_clk);
  endtask : set_irq
endmodule : rxi_board

// ===== sim/testbench.sv
// Self-checking bench for the reset and external interrupt front end
`timescale 1ns/1ps
module testbench;
  import rxi_pkg::*;
  logic core_clk, rst_b, wd, mask, r1, r2, gm, dir, dout;
  logic rp, nmi_b, b1, b2, p1_out, p1_oe, rp_out, rp_oe, halt, pcz, fs, io_in;
  logic nmi_r, q1, q2, cs, qm;
  logic [15:0] fa;
  int mismatches = 0, num_checks = 0, cyc = 0, cnt [7], base [7];
  wire p1 = p1_oe ? p1_out : b1;
  wire [6:0] sig = {qm, fs, rp_oe, cs, q2, q1, nmi_r};
  rxi_board u_rxi_board (.core_clk(core_clk), .rst_oe(rp_oe), .rst_lvl(rp),
    .nmi_b(nmi_b), .irq1(b1), .irq2(b2));
  rxi_reset_irq u_rxi_reset_irq (.core_clk(core_clk), .rst_b(rst_b),
    .system_reset_pin_in(rp), .system_reset_pin_out(rp_out), .system_reset_pin_oe(rp_oe),
    .wd_overflow(wd), .core_halt(halt), .pc_force_zero(pcz), .fetch_addr(fa),
    .fetch_start(fs), .global_irq_mask(mask), .nmi_b_pin(nmi_b), .nmi_req(nmi_r),
    .user_irq_one_pin_in(p1), .user_irq_one_pin_out(p1_out), .user_irq_one_pin_oe(p1_oe),
    .irq_one_rise_sel(r1), .irq_one_gpio_mode(gm), .port_a_bit2_io_dir(dir),
    .port_a_bit2_io_out(dout), .port_a_bit2_io_in(io_in), .user_irq_one_req(q1),
    .user_irq_two_pin(b2), .irq_two_rise_sel(r2), .user_irq_two_req(q2),
    .conv_start_req(cs), .user_irq_req_masked(qm));
  // ==========================================================
  // Clock, high-cycle counters, timeout
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    for (int i = 0; i < 7; i++) cnt[i] <= cnt[i] + int'(sig[i] === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  task print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt
  function automatic logic [15:0] d(input int i);
    return 16'(cnt[i] - base[i]);
  endfunction : d
  // ==========================================================
  // Scenarios
  task t_pin_reset();
    base = cnt;
    u_rxi_board.hold_rst(10);
    chk("halt", 16'h0001, {halt, pcz} == 2'b11 ? 16'h0001 : 16'h0000);
    wt(10);
    chk("restart", 16'h0001, d(5));
    chk("fetch_addr", RXI_RESET_VECTOR, fa | {15'h0000, halt});
  endtask : t_pin_reset
  task t_watchdog();
    base = cnt;
    wd = 1'b1;
    wt(1);
    wd = 1'b0;
    wt(20);
    chk("wd_oe", 16'(RXI_WD_PULSE_CYCLES), d(4));
    chk("wd_restart", 16'h0001, d(5) | {15'h0000, rp_out});
  endtask : t_watchdog
  task t_nmi();
    mask = 1'b1;
    base = cnt;
    u_rxi_board.nmi_pulse();
    wt(8);
    chk("nmi_req", 16'h0001, d(0));
  endtask : t_nmi
  task t_irq(input logic s);
    {r1, r2, mask} = {s, s, s};
    base = cnt;
    u_rxi_board.set_irq(1'b1, 1'b1);
    u_rxi_board.set_irq(1'b0, 1'b1);
    wt(3);
    chk("irq1_rise", {15'h0000, s}, d(1));
    chk("irq2_rise", {15'h0000, s}, d(2));
    u_rxi_board.set_irq(1'b1, 1'b0);
    u_rxi_board.set_irq(1'b0, 1'b0);
    wt(6);
    chk("irq1_both", 16'h0001, d(1));
    chk("irq2_both", 16'h0001, d(2));
    chk("conv_start", 16'h0001, d(3));
    chk("masked", s ? 16'h0000 : 16'h0002, d(6));
  endtask : t_irq
  task t_gpio();
    {gm, dir, dout} = 3'b111;
    wt(3);
    chk("gpio_drive", 16'h0003, {14'h0000, p1_oe, p1_out});
    dir = 1'b0;
    base = cnt;
    u_rxi_board.set_irq(1'b1, 1'b1);
    wt(2);
    chk("gpio_in", 16'h0001, {15'h0000, io_in});
    chk("gpio_no_irq", 16'h0000, d(1));
    u_rxi_board.set_irq(1'b1, 1'b0);
    wt(1);
    gm = 1'b0;
  endtask : t_gpio
  initial begin
    {wd, mask, r1, r2, gm, dir, dout} = 7'h00;
    for (int i = 0; i < 7; i++) cnt[i] = 0;
    rst_b = 1'b0;
    wt(12);
    rst_b = 1'b1;
    wt(10);
    chk("boot_halt", 16'h0000, {15'h0000, halt});
    t_pin_reset();
    t_watchdog();
    t_nmi();
    t_irq(1'b0);
    t_irq(1'b1);
    t_gpio();
    print_verdict();
  end
endmodule : testbench
